/* File: hdl/hrs_pkg.sv */
package hrs_pkg;

    // clock rate and pin timing
    localparam int CLK_MHZ = 10;
    localparam int T_RST_NS = 65;
    localparam int RST_CYC_RAW = (T_RST_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] RST_CYC = 4'((RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW);

    // serial stream geometry
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int KEY_BITS = 64;
    localparam int NUM_CLK_REGS = 8;
    localparam logic [5:0] LAST_BIT = 6'h3f;
    localparam logic [2:0] LAST_BIT_IN_BYTE = 3'h7;

    // apb register map, byte addresses
    localparam int APB_AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_SCRATCH = 8'h08;
    localparam logic [7:0] OFF_KEY_LO = 8'h0c;
    localparam logic [7:0] OFF_KEY_HI = 8'h10;
    localparam logic [7:0] OFF_CLK_BASE = 8'h20;
    localparam logic [7:0] OFF_CLK_LAST = 8'h3c;

    // control register bits (write-only pulses)
    localparam int CTRL_GO_RD = 0;
    localparam int CTRL_GO_WR = 1;
    localparam int CTRL_RST_PULSE = 2;

    // status register bits
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ABORTED = 2;
    localparam int ST_MODE12 = 3;
    localparam int ST_PM20 = 4;
    localparam int ST_RST_IGN = 5;
    localparam int ST_OSC_STOP = 6;

    // clock register layout inside the stream
    localparam logic [2:0] IDX_HOURS = 3'h3;
    localparam logic [2:0] IDX_DAY = 3'h4;
    localparam int HOURS_MODE_BIT = 7;
    localparam int HOURS_PM_BIT = 5;
    localparam int DAY_RST_GATE_BIT = 4;
    localparam int DAY_OSC_BIT = 5;

    // reset values
    localparam logic [63:0] KEY_DEFAULT = 64'h5a3c_96e1_0f78_c3a5;
    localparam logic [16:0] SCRATCH_RST = 17'h00000;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b000,
        ENG_SETUP = 3'b001,
        ENG_STROBE = 3'b010,
        ENG_RECOV = 3'b011,
        ENG_FETCH = 3'b100,
        ENG_LOAD = 3'b101
    } hrs_eng_e;

    typedef enum logic [1:0] {
        PH_SYNC = 2'b00,
        PH_KEY = 2'b01,
        PH_XFER = 2'b10
    } hrs_phase_e;

    // pins toward the timekeeping memory socket
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic [16:0] byte_address_lines;
        logic [7:0] data_lines;
        logic data_lines_oe;
    } hrs_pins_s;

    typedef struct packed {
        hrs_eng_e st;
        hrs_phase_e phase;
        logic [5:0] bitcnt;
        logic rd_op;
        logic cyc_rd;
        logic [7:0] shift;
        logic done;
        logic aborted;
        logic [16:0] scratch;
        logic [63:0] key;
        logic [31:0] prdata;
        logic pslverr;
        logic mode12;
        logic pm20;
        logic rst_ign;
        logic osc_stop;
        logic [3:0] rst_cnt;
        hrs_pins_s pins;
    } hrs_state_s;

endpackage

/* File: hdl/hrs_byte_mem.sv */
`timescale 1ns/1ps
module hrs_byte_mem (
    input wire logic clk_in,
    input wire logic en_in,
    input wire logic we_in,
    input wire logic [2:0] waddr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [2:0] raddr_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [0:hrs_pkg::NUM_CLK_REGS-1];

    always_ff @(posedge clk_in) begin
        if (en_in) begin
            if (we_in) begin
                mem[waddr_in] <= wdata_in;
            end
            rdata_out <= mem[raddr_in];
        end
    end
endmodule

/* File: hdl/hrs_host.sv */
`timescale 1ns/1ps
// What this block does
// - unlock by 64 write cycles, one key bit each on data bit 0
// - a read to any address restarts key compare; host reads first
// - transfer walks all eight registers, bit 0 of reg 0 to bit 7 of reg 7
// - host writes each clock register as a whole 8-bit group
// - key writes also store to memory; use one scratch address
// - read cycle: chip enable low, write enable high, 17 address lines
// - write spans later strobe fall to earlier rise, address held stable
module hrs_host (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output hrs_pkg::hrs_pins_s pins_out,
    input wire logic [7:0] data_lines_in
);
    hrs_pkg::hrs_state_s state_reg;
    hrs_pkg::hrs_state_s state_next;
    logic mem_we;
    logic [2:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [2:0] mem_raddr;
    logic [7:0] mem_rdata;
    logic apb_setup;
    logic apb_acc;
    logic abort_req;
    logic [31:0] status_word;

    function automatic logic is_clk_addr(input logic [7:0] a);
        is_clk_addr = (a >= hrs_pkg::OFF_CLK_BASE) && (a <= hrs_pkg::OFF_CLK_LAST)
            && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [2:0] clk_idx(input logic [7:0] a);
        clk_idx = a[4:2];
    endfunction

    // mirror the mode and control bits of a clock byte as it passes by
    function automatic hrs_pkg::hrs_state_s note_byte(input hrs_pkg::hrs_state_s x,
                                                     input logic [2:0] idx,
                                                     input logic [7:0] b);
        note_byte = x;
        if (idx == hrs_pkg::IDX_HOURS) begin
            note_byte.mode12 = b[hrs_pkg::HOURS_MODE_BIT];
            note_byte.pm20 = b[hrs_pkg::HOURS_PM_BIT];
        end
        if (idx == hrs_pkg::IDX_DAY) begin
            note_byte.rst_ign = b[hrs_pkg::DAY_RST_GATE_BIT];
            note_byte.osc_stop = b[hrs_pkg::DAY_OSC_BIT];
        end
    endfunction

    hrs_byte_mem u_mem (
        .clk_in(mclk_in),
        .en_in(clk_en_in),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(mem_wdata),
        .raddr_in(mem_raddr),
        .rdata_out(mem_rdata)
    );

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[hrs_pkg::ST_BUSY] = (state_reg.st != hrs_pkg::ENG_IDLE);
        status_word[hrs_pkg::ST_DONE] = state_reg.done;
        status_word[hrs_pkg::ST_ABORTED] = state_reg.aborted;
        status_word[hrs_pkg::ST_MODE12] = state_reg.mode12;
        status_word[hrs_pkg::ST_PM20] = state_reg.pm20;
        status_word[hrs_pkg::ST_RST_IGN] = state_reg.rst_ign;
        status_word[hrs_pkg::ST_OSC_STOP] = state_reg.osc_stop;
    end

    always_comb begin
        state_next = state_reg;
        apb_setup = psel_in & ~penable_in;
        apb_acc = psel_in & penable_in;
        abort_req = 1'b0;
        mem_we = 1'b0;
        mem_waddr = state_reg.bitcnt[5:3];
        mem_wdata = state_reg.shift;
        mem_raddr = state_reg.bitcnt[5:3];

        // read data is prepared in the setup cycle so the access phase is one cycle
        if (apb_setup) begin
            state_next.prdata = 32'h0000_0000;
            state_next.pslverr = 1'b0;
            if (paddr_in == hrs_pkg::OFF_CTRL) begin
                state_next.prdata = 32'h0000_0000;
            end else if (paddr_in == hrs_pkg::OFF_STATUS) begin
                state_next.prdata = status_word;
            end else if (paddr_in == hrs_pkg::OFF_SCRATCH) begin
                state_next.prdata = {15'h0000, state_reg.scratch};
            end else if (paddr_in == hrs_pkg::OFF_KEY_LO) begin
                state_next.prdata = state_reg.key[31:0];
            end else if (paddr_in == hrs_pkg::OFF_KEY_HI) begin
                state_next.prdata = state_reg.key[63:32];
            end else if (is_clk_addr(paddr_in)) begin
                mem_raddr = clk_idx(paddr_in);
            end else begin
                state_next.pslverr = 1'b1;
            end
        end

        if (apb_acc && pwrite_in) begin
            if (paddr_in == hrs_pkg::OFF_CTRL) begin
                if (pwdata_in[hrs_pkg::CTRL_RST_PULSE] && state_reg.rst_cnt == 4'h0) begin
                    state_next.rst_cnt = hrs_pkg::RST_CYC;
                    abort_req = ~state_reg.rst_ign;
                end
                if (state_reg.st == hrs_pkg::ENG_IDLE &&
                    (pwdata_in[hrs_pkg::CTRL_GO_RD] || pwdata_in[hrs_pkg::CTRL_GO_WR])) begin
                    // read wins when both are set; the opening read re-arms compare
                    state_next.rd_op = pwdata_in[hrs_pkg::CTRL_GO_RD];
                    state_next.phase = hrs_pkg::PH_SYNC;
                    state_next.cyc_rd = 1'b1;
                    state_next.bitcnt = 6'h00;
                    state_next.done = 1'b0;
                    state_next.aborted = 1'b0;
                    state_next.st = hrs_pkg::ENG_SETUP;
                end
            end else if (state_reg.st == hrs_pkg::ENG_IDLE) begin
                // settings and clock bytes are frozen while a stream runs
                if (paddr_in == hrs_pkg::OFF_SCRATCH) begin
                    state_next.scratch = pwdata_in[16:0];
                end else if (paddr_in == hrs_pkg::OFF_KEY_LO) begin
                    state_next.key[31:0] = pwdata_in;
                end else if (paddr_in == hrs_pkg::OFF_KEY_HI) begin
                    state_next.key[63:32] = pwdata_in;
                end else if (is_clk_addr(paddr_in)) begin
                    mem_we = 1'b1;
                    mem_waddr = clk_idx(paddr_in);
                    mem_wdata = pwdata_in[7:0];
                    state_next = note_byte(state_next, clk_idx(paddr_in), pwdata_in[7:0]);
                end
            end
        end

        case (state_reg.st)
            hrs_pkg::ENG_IDLE: begin
            end
            hrs_pkg::ENG_SETUP: begin
                state_next.st = hrs_pkg::ENG_STROBE;
            end
            hrs_pkg::ENG_STROBE: begin
                if (state_reg.cyc_rd && state_reg.phase == hrs_pkg::PH_XFER) begin
                    // bits arrive lsb first
                    state_next.shift = {data_lines_in[0], state_reg.shift[7:1]};
                end
                state_next.st = hrs_pkg::ENG_RECOV;
            end
            hrs_pkg::ENG_RECOV: begin
                state_next.st = hrs_pkg::ENG_SETUP;
                if (state_reg.phase == hrs_pkg::PH_SYNC) begin
                    state_next.phase = hrs_pkg::PH_KEY;
                    state_next.bitcnt = 6'h00;
                    state_next.cyc_rd = 1'b0;
                end else if (state_reg.phase == hrs_pkg::PH_KEY) begin
                    if (state_reg.bitcnt == hrs_pkg::LAST_BIT) begin
                        state_next.phase = hrs_pkg::PH_XFER;
                        state_next.bitcnt = 6'h00;
                        state_next.cyc_rd = state_reg.rd_op;
                        if (!state_reg.rd_op) begin
                            state_next.st = hrs_pkg::ENG_FETCH;
                        end
                    end else begin
                        state_next.bitcnt = state_reg.bitcnt + 6'h01;
                    end
                end else begin
                    if (state_reg.rd_op && state_reg.bitcnt[2:0] == hrs_pkg::LAST_BIT_IN_BYTE) begin
                        mem_we = 1'b1;
                        mem_waddr = state_reg.bitcnt[5:3];
                        mem_wdata = state_reg.shift;
                        state_next = note_byte(state_next, state_reg.bitcnt[5:3],
                                               state_reg.shift);
                    end
                    if (!state_reg.rd_op) begin
                        state_next.shift = {1'b0, state_reg.shift[7:1]};
                    end
                    if (state_reg.bitcnt == hrs_pkg::LAST_BIT) begin
                        // the device relocks on its own after the last bit
                        state_next.st = hrs_pkg::ENG_IDLE;
                        state_next.done = 1'b1;
                    end else begin
                        state_next.bitcnt = state_reg.bitcnt + 6'h01;
                        if (!state_reg.rd_op &&
                            state_reg.bitcnt[2:0] == hrs_pkg::LAST_BIT_IN_BYTE) begin
                            state_next.st = hrs_pkg::ENG_FETCH;
                        end
                    end
                end
            end
            hrs_pkg::ENG_FETCH: begin
                // the bus owns the read port during its setup cycle
                if (!apb_setup) begin
                    state_next.st = hrs_pkg::ENG_LOAD;
                end
            end
            hrs_pkg::ENG_LOAD: begin
                state_next.shift = mem_rdata;
                state_next = note_byte(state_next, state_reg.bitcnt[5:3], mem_rdata);
                state_next.st = hrs_pkg::ENG_SETUP;
            end
            default: begin
                state_next.st = hrs_pkg::ENG_IDLE;
            end
        endcase

        if (state_reg.rst_cnt != 4'h0) begin
            state_next.rst_cnt = state_reg.rst_cnt - 4'h1;
        end

        // a reset pulse that the device honours kills its transfer, so stop ours
        if (abort_req && state_reg.st != hrs_pkg::ENG_IDLE) begin
            state_next.st = hrs_pkg::ENG_IDLE;
            state_next.aborted = 1'b1;
        end

        // only selected cycles are issued, so nothing interleaves with the stream
        state_next.pins.ce_n = (state_next.st != hrs_pkg::ENG_STROBE);
        state_next.pins.oe_n = ~((state_next.st == hrs_pkg::ENG_STROBE) &
                                 state_next.cyc_rd);
        state_next.pins.we_n = ~((state_next.st == hrs_pkg::ENG_STROBE) &
                                 ~state_next.cyc_rd);
        state_next.pins.byte_address_lines = state_next.scratch;
        state_next.pins.data_lines_oe = ((state_next.st == hrs_pkg::ENG_STROBE) ||
                                         (state_next.st == hrs_pkg::ENG_RECOV)) &&
                                        ~state_next.cyc_rd;
        if (state_next.phase == hrs_pkg::PH_KEY) begin
            state_next.pins.data_lines = {7'h00, state_next.key[state_next.bitcnt]};
        end else begin
            state_next.pins.data_lines = {7'h00, state_next.shift[0]};
        end
        state_next.pins.rst_n = (state_next.rst_cnt == 4'h0);
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_reg <= '0;
            state_reg.st <= hrs_pkg::ENG_IDLE;
            state_reg.phase <= hrs_pkg::PH_SYNC;
            state_reg.key <= hrs_pkg::KEY_DEFAULT;
            state_reg.scratch <= hrs_pkg::SCRATCH_RST;
            state_reg.rst_ign <= 1'b1;
            state_reg.osc_stop <= 1'b1;
            state_reg.pins.ce_n <= 1'b1;
            state_reg.pins.oe_n <= 1'b1;
            state_reg.pins.we_n <= 1'b1;
            state_reg.pins.rst_n <= 1'b1;
        end else if (clk_en_in) begin
            state_reg <= state_next;
        end
    end

    // clock bytes come straight from the memory's output register
    always_comb begin
        if (is_clk_addr(paddr_in)) begin
            prdata_out = {24'h000000, mem_rdata};
        end else begin
            prdata_out = state_reg.prdata;
        end
    end

    assign pready_out = psel_in & penable_in;
    assign pslverr_out = psel_in & penable_in & state_reg.pslverr;
    assign pins_out = state_reg.pins;
endmodule

/* File: tb/hrs_host_checker.sv */
`timescale 1ns/1ps
module hrs_host_checker (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire hrs_pkg::hrs_pins_s pins_out,
    input wire logic [7:0] data_lines_in
);
    logic acc;
    logic go;
    logic [7:0] cnt_reg;
    logic pend_reg;
    logic rd_op_reg;
    assign acc = psel_in && penable_in;
    assign go = acc && pwrite_in && paddr_in == hrs_pkg::OFF_CTRL && pwdata_in[1:0] != 2'h0;
    // strobe index since the last start: 0 sync read, 1..64 key, 65..128 transfer
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            cnt_reg <= 8'h00;
            pend_reg <= 1'b0;
            rd_op_reg <= 1'b0;
        end else if (go) begin
            cnt_reg <= 8'h00;
            pend_reg <= 1'b1;
            rd_op_reg <= pwdata_in[0];
        end else if (!pins_out.ce_n) begin
            cnt_reg <= cnt_reg + 8'h01;
            pend_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    property p_ready; acc |-> pready_out; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access cycle");
    property p_err; acc && paddr_in > 8'h3c |-> pslverr_out; endproperty
    a_err: assert property (p_err) else $error("unmapped access without error");
    property p_go; go |-> ##[2:3] !pins_out.ce_n; endproperty
    a_go: assert property (p_go) else $error("start did not open a pin cycle");
    property p_one; $fell(pins_out.ce_n) |=> pins_out.ce_n; endproperty
    a_one: assert property (p_one) else $error("strobe longer than one clock");
    property p_gap; $rose(pins_out.ce_n) |=> pins_out.ce_n; endproperty
    a_gap: assert property (p_gap) else $error("pin cycles too close");
    property p_wr_shape;
        !pins_out.we_n |-> !pins_out.ce_n && pins_out.oe_n && pins_out.data_lines_oe
            && pins_out.data_lines[7:1] == 7'h00;
    endproperty
    a_wr_shape: assert property (p_wr_shape) else $error("bad write cycle");
    property p_rd_shape;
        !pins_out.oe_n |-> !pins_out.ce_n && pins_out.we_n && !pins_out.data_lines_oe;
    endproperty
    a_rd_shape: assert property (p_rd_shape) else $error("bad read cycle");
    property p_addr; !pins_out.ce_n |-> $stable(pins_out.byte_address_lines); endproperty
    a_addr: assert property (p_addr) else $error("address moved in cycle");
    property p_first_rd; pend_reg && !pins_out.ce_n |-> pins_out.we_n; endproperty
    a_first_rd: assert property (p_first_rd) else $error("sequence not opened by read");
    property p_key; !pins_out.ce_n && cnt_reg inside {[8'h01:8'h40]} |-> !pins_out.we_n;
    endproperty
    a_key: assert property (p_key) else $error("key phase not 64 writes");
    property p_xfer; !pins_out.ce_n && cnt_reg > 8'h40 |-> pins_out.we_n == rd_op_reg;
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer direction wrong");
    property p_count; !pins_out.ce_n |-> cnt_reg <= 8'h80; endproperty
    a_count: assert property (p_count) else $error("more than 129 pin cycles");
    property p_rst;
        acc && pwrite_in && paddr_in == hrs_pkg::OFF_CTRL && pwdata_in[2]
            |-> ##[1:2] !pins_out.rst_n;
    endproperty
    a_rst: assert property (p_rst) else $error("reset pulse missing");
    property p_rst_w; $fell(pins_out.rst_n) |=> pins_out.rst_n; endproperty
    a_rst_w: assert property (p_rst_w) else $error("reset pulse too long");
    c_rd: cover property (go && pwdata_in[0]);
    c_wr: cover property (go && pwdata_in[1]);
    c_rst: cover property ($fell(pins_out.rst_n));
    c_err: cover property (acc && pslverr_out);
endmodule
bind hrs_host hrs_host_checker u_chk (.mclk_in(mclk_in), .srst_in(srst_in),
    .clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .pins_out(pins_out), .data_lines_in(data_lines_in));

/* File: tb/hrs_dev_model.sv */
`timescale 1ns/1ps
module hrs_dev_model #(
    parameter logic [63:0] KEY = 64'h0,
    parameter logic [63:0] INIT = 64'h0
) (
    input wire logic mclk_in,
    input wire hrs_pkg::hrs_pins_s pins_in,
    output logic [7:0] data_out
);
    logic [63:0] regs = INIT | 64'h0000_0030_0000_0000;
    logic [6:0] ptr = 7'h00;
    logic miss = 1'b0;
    logic open_q = 1'b0;
    logic [6:0] xcnt = 7'h00;
    logic [16:0] mem_addr = 17'h00000;
    logic [7:0] mem_data = 8'h00;
    logic [7:0] last = 8'h00;
    logic rd;
    logic wr;
    assign rd = !pins_in.ce_n && pins_in.we_n;
    assign wr = !pins_in.ce_n && !pins_in.we_n;
    always_comb begin
        if (rd && !pins_in.oe_n) begin
            if (open_q) data_out = {7'h00, regs[xcnt[5:0]]};
            else data_out = (pins_in.byte_address_lines == mem_addr) ? mem_data : 8'h00;
        end else begin
            data_out = ~last; // released bus has no pull, so show the inverse
        end
    end
    always @(posedge mclk_in) begin
        if (rd && !pins_in.oe_n) last <= data_out;
        if (!pins_in.rst_n && !regs[36] && open_q) begin
            open_q <= 1'b0;
            xcnt <= 7'h00;
        end else if (open_q && (rd || wr)) begin
            if (wr) regs[xcnt[5:0]] <= pins_in.data_lines[0];
            xcnt <= xcnt + 7'h01;
            if (xcnt == 7'h3f) begin
                open_q <= 1'b0;
                xcnt <= 7'h00;
            end
        end else if (rd) begin
            ptr <= 7'h00;
            miss <= 1'b0;
        end else if (wr) begin
            mem_addr <= pins_in.byte_address_lines;
            mem_data <= pins_in.data_lines;
            if (!miss && pins_in.data_lines[0] == KEY[ptr[5:0]]) begin
                ptr <= ptr + 7'h01;
                if (ptr == 7'h3f) open_q <= 1'b1;
            end else begin
                miss <= 1'b1;
            end
        end
    end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam logic [63:0] KEY = 64'hc3a5_1e87_69d2_4b0f;
    localparam logic [63:0] INIT = 64'h2406_1534_b130_5900;
    localparam logic [63:0] WR = 64'h2507_1404_2345_1200;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    hrs_pkg::hrs_pins_s pins;
    logic [7:0] dev_data;
    logic [31:0] rd;
    logic err;
    logic clk_en = 1'b1;
    int failures = 0;
    int checked = 0;
    always #50 mclk = ~mclk;
    hrs_host u_dut (.mclk_in(mclk), .srst_in(srst), .clk_en_in(clk_en), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pins_out(pins),
        .data_lines_in(dev_data));
    hrs_dev_model #(.KEY(KEY), .INIT(INIT)) u_dev (.mclk_in(mclk), .pins_in(pins),
        .data_out(dev_data));
    task automatic results();
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            $display("ERROR %0t: no bus answer", $time);
            results();
        end
        @(posedge mclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // the design gives no completion pulse, so poll busy with a cap
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, hrs_pkg::OFF_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            failures++;
            $display("ERROR %0t: engine stuck busy", $time);
            results();
        end
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd_chk(hrs_pkg::OFF_STATUS, 32'h60);
        rd_chk(hrs_pkg::OFF_SCRATCH, 32'h0);
        apb(1'b0, 8'h44, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, hrs_pkg::OFF_SCRATCH, 32'h123);
        // a write while the enable is low must leave every register untouched
        clk_en <= 1'b0;
        apb(1'b1, hrs_pkg::OFF_SCRATCH, 32'h55);
        clk_en <= 1'b1;
        rd_chk(hrs_pkg::OFF_SCRATCH, 32'h123);
        apb(1'b1, hrs_pkg::OFF_KEY_LO, KEY[31:0]);
        apb(1'b1, hrs_pkg::OFF_KEY_HI, KEY[63:32]);
        apb(1'b1, hrs_pkg::OFF_CTRL, 32'h1);
        wait_idle();
        rd_chk(hrs_pkg::OFF_STATUS, 32'h7a);
        for (int i = 0; i < 8; i++) begin
            rd_chk(hrs_pkg::OFF_CLK_BASE + 8'(4 * i), {24'h0, INIT[8 * i +: 8]});
        end
        chk(u_dev.mem_addr, 17'h00123);
        chk(u_dev.mem_data, {7'h00, KEY[63]});
        // wrong first key bit: every cycle must land in plain memory
        apb(1'b1, hrs_pkg::OFF_KEY_LO, KEY[31:0] ^ 32'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, hrs_pkg::OFF_CLK_BASE + 8'(4 * i), {24'h0, WR[8 * i +: 8]});
        end
        apb(1'b1, hrs_pkg::OFF_CTRL, 32'h2);
        wait_idle();
        chk(u_dev.regs, INIT);
        chk(u_dev.mem_data, {7'h00, WR[63]});
        apb(1'b1, hrs_pkg::OFF_KEY_LO, KEY[31:0]);
        apb(1'b1, hrs_pkg::OFF_CTRL, 32'h2);
        wait_idle();
        chk(u_dev.regs, WR);
        chk(u_dev.mem_data, {7'h00, KEY[63]});
        rd_chk(hrs_pkg::OFF_STATUS, 32'h12);
        // reset pin now honoured: let the key pass so the pulse lands in the transfer
        apb(1'b1, hrs_pkg::OFF_CTRL, 32'h1);
        repeat (68) apb(1'b0, hrs_pkg::OFF_STATUS, 32'h0);
        chk(rd[0], 1'b1);
        chk(u_dev.open_q, 1'b1);
        apb(1'b1, hrs_pkg::OFF_CTRL, 32'h4);
        wait_idle();
        chk(rd[2:0], 3'h4);
        chk(u_dev.open_q, 1'b0);
        chk(u_dev.regs, WR);
        results();
    end
endmodule
